/* sdmr_pkg.sv */
/*
  Package for the SDRAM mode register block: command encodings, mode
  register and extended register one field positions, decode enums.
  Assumes nothing of its surroundings; shared by the core and the decoder.
*/
package sdmr_pkg;

  // Address and bank widths
  localparam int ADDR_W = 13;
  localparam int BANK_W = 2;

  // Bank codes that select the register written by a register-set command
  localparam logic [1:0] BANK_MODE = 2'h0;
  localparam logic [1:0] BANK_EXT1 = 2'h1;
  localparam logic [1:0] BANK_EXT2 = 2'h2;
  localparam logic [1:0] BANK_EXT3 = 2'h3;

  // Mode register field positions
  localparam int MR_BL_LSB = 0;
  localparam int MR_BT_BIT = 3;
  localparam int MR_CL_LSB = 4;
  localparam int MR_TM_BIT = 7;
  localparam int MR_DLLRST_BIT = 8;
  localparam int MR_WR_LSB = 9;

  // Extended register one field positions
  localparam int E1_DLLDIS_BIT = 0;
  localparam int E1_HALF_BIT = 1;
  localparam int E1_RTT0_BIT = 2;
  localparam int E1_AL_LSB = 3;
  localparam int E1_RTT1_BIT = 6;
  localparam int E1_OCD_LSB = 7;
  localparam int E1_NDQS_BIT = 10;
  localparam int E1_QOFF_BIT = 12;

  // Burst length codes
  localparam logic [2:0] BL_CODE_4 = 3'h2;
  localparam logic [2:0] BL_CODE_8 = 3'h3;

  // Column address bit that requests auto precharge
  localparam int AP_BIT = 10;

  // Driver calibration codes
  localparam logic [2:0] OCD_EXIT = 3'h0;
  localparam logic [2:0] OCD_DEFAULT = 3'h7;

  // Lock time of the delay line after reset, in clocks
  localparam int DLL_LOCK_CLKS = 200;

  // Register reset values (register contents undefined until written)
  localparam logic [12:0] MR_RESET = 13'h0000;
  localparam logic [12:0] E1_RESET = 13'h0000;

  // Decoded commands on the pins
  typedef enum logic [2:0] {
    SDMR_NOP,
    SDMR_ACT,
    SDMR_READ,
    SDMR_WRITE,
    SDMR_PRE,
    SDMR_REF,
    SDMR_MRS
  } sdmr_cmd_t;

endpackage : sdmr_pkg

/* sdmr_cmd_dec.sv */
/*
  Command decoder: turns sampled chip select, row/column strobe and write
  enable levels into one command code. Assumes already synchronised inputs.
*/
`timescale 1ns/1ns
module sdmr_cmd_dec (
  // Sampled command pins, active low
  input wire logic cs_n_in,
  input wire logic ras_n_in,
  input wire logic cas_n_in,
  input wire logic we_n_in,
  // Decoded command
  output sdmr_pkg::sdmr_cmd_t cmd_out
);
  import sdmr_pkg::*;

  // Truth table of the command pins
  always_comb begin
    if (cs_n_in) begin
      cmd_out = SDMR_NOP; // Deselect
    end else begin
      unique case ({ras_n_in, cas_n_in, we_n_in})
        3'h3: cmd_out = SDMR_ACT;
        3'h5: cmd_out = SDMR_READ;
        3'h4: cmd_out = SDMR_WRITE;
        3'h2: cmd_out = SDMR_PRE;
        3'h1: cmd_out = SDMR_REF;
        3'h0: cmd_out = SDMR_MRS;
        default: cmd_out = SDMR_NOP;
      endcase
    end
  end

endmodule : sdmr_cmd_dec

/* sdmr_core.sv */
/*
  SDRAM mode register core: samples the command pins on rising edges of the
  controller clock, holds the mode register and extended register one,
  tracks open banks, the delay line state and access decoding.
  Assumes a free 25 MHz local clock much faster than the link clock.
*/
`timescale 1ns/1ns
module sdmr_core #(
  parameter int NUM_BANKS = 4 // Banks tracked for idle state
) (
  // Clock and reset
  input wire logic REF_CLK_IN,
  input wire logic RESET_IN,
  // Pins from the controller
  input wire logic CK_IN,
  input wire logic CKE_IN,
  input wire logic CS_N_IN,
  input wire logic RAS_N_IN,
  input wire logic CAS_N_IN,
  input wire logic WE_N_IN,
  input wire logic [sdmr_pkg::BANK_W-1:0] BA_IN,
  input wire logic [sdmr_pkg::ADDR_W-1:0] A_IN,
  // Register contents and state
  output logic [sdmr_pkg::ADDR_W-1:0] MODE_REG_OUT,
  output logic [sdmr_pkg::ADDR_W-1:0] EXT1_REG_OUT,
  output logic MODE_VALID_OUT,
  output logic EXT1_VALID_OUT,
  output logic DLL_ON_OUT,
  output logic DLL_LOCKED_OUT,
  output logic SELF_REFRESH_OUT,
  output logic ALL_IDLE_OUT,
  // Access decode
  output logic [3:0] BURST_LEN_OUT,
  output logic [sdmr_pkg::BANK_W-1:0] ACT_BANK_OUT,
  output logic [sdmr_pkg::ADDR_W-1:0] ACT_ROW_OUT,
  output logic [sdmr_pkg::ADDR_W-1:0] COL_OUT,
  output logic AUTO_PRE_OUT,
  output logic ACCESS_WRITE_OUT,
  output logic ACCESS_STB_OUT,
  output logic MRS_ERR_OUT
);
  import sdmr_pkg::*;

  // Synchroniser stages for every pin, two flops each
  localparam int PIN_W = 6 + BANK_W + ADDR_W;
  logic [PIN_W-1:0] sync1_q, sync2_q;
  logic [PIN_W-1:0] pins_raw;
  logic ck_d1_q; // Previous synchronised clock level
  logic ck_rise;
  logic cke_s, cs_n_s, ras_n_s, cas_n_s, we_n_s;
  logic [BANK_W-1:0] ba_s;
  logic [ADDR_W-1:0] a_s;
  sdmr_cmd_t cmd;

  assign pins_raw = {CK_IN, CKE_IN, CS_N_IN, RAS_N_IN, CAS_N_IN, WE_N_IN, BA_IN, A_IN};
  assign {cke_s, cs_n_s, ras_n_s, cas_n_s, we_n_s, ba_s, a_s} = sync2_q[PIN_W-2:0];
  assign ck_rise = sync2_q[PIN_W-1] & ~ck_d1_q;

  // Two flip-flop synchroniser; only sync2 is read by logic
  always_ff @(posedge REF_CLK_IN) begin
    if (RESET_IN) begin
      sync1_q <= '0;
      sync2_q <= '0;
      ck_d1_q <= 1'b0;
    end else begin
      sync1_q <= pins_raw;
      sync2_q <= sync1_q;
      ck_d1_q <= sync2_q[PIN_W-1];
    end
  end

  // Command decode of the sampled pins
  sdmr_cmd_dec u_dec (
    .cs_n_in(cs_n_s),
    .ras_n_in(ras_n_s),
    .cas_n_in(cas_n_s),
    .we_n_in(we_n_s),
    .cmd_out(cmd)
  );

  // Burst length decode, used only for the output
  function automatic logic [3:0] burst_len(input logic [2:0] code);
    if (code == BL_CODE_8) begin
      burst_len = 4'h8;
    end else begin
      burst_len = 4'h4;
    end
  endfunction : burst_len

  // State registers
  logic [ADDR_W-1:0] mr_q, mr_d, e1_q, e1_d;
  logic mr_v_q, mr_v_d, e1_v_q, e1_v_d;
  logic [NUM_BANKS-1:0] open_q, open_d;
  logic sref_q, sref_d;
  logic [7:0] lock_q, lock_d; // Clocks since delay line reset
  logic locking_q, locking_d;
  logic [BANK_W-1:0] abank_q, abank_d;
  logic [ADDR_W-1:0] arow_q, arow_d, col_q, col_d;
  logic ap_q, ap_d, wr_q, wr_d, stb_q, stb_d, err_q, err_d;
  logic cke_prev_q, cke_prev_d;

  // Next state of registers, banks, delay line and access decode
  always_comb begin
    mr_d = mr_q;
    e1_d = e1_q;
    mr_v_d = mr_v_q;
    e1_v_d = e1_v_q;
    open_d = open_q;
    sref_d = sref_q;
    lock_d = lock_q;
    locking_d = locking_q;
    abank_d = abank_q;
    arow_d = arow_q;
    col_d = col_q;
    ap_d = ap_q;
    wr_d = wr_q;
    stb_d = 1'b0;
    err_d = 1'b0;
    cke_prev_d = cke_prev_q;
    if (ck_rise) begin
      cke_prev_d = cke_s;
      // Delay line lock counter runs on link clocks
      if (locking_q && !sref_q) begin
        if (lock_q == 8'(DLL_LOCK_CLKS - 1)) begin
          locking_d = 1'b0;
        end else begin
          lock_d = lock_q + 8'h01;
        end
      end
      if (sref_q) begin
        // Self refresh exits when enable returns high
        if (cke_s) begin
          sref_d = 1'b0;
        end
      end else if (cke_s && cke_prev_q) begin
        unique case (cmd)
          SDMR_ACT: begin
            open_d[ba_s] = 1'b1;
            abank_d = ba_s;
            arow_d = a_s;
          end
          SDMR_READ, SDMR_WRITE: begin
            col_d = a_s;
            ap_d = a_s[AP_BIT];
            wr_d = (cmd == SDMR_WRITE);
            stb_d = 1'b1;
            if (ap_d) begin
              open_d[ba_s] = 1'b0;
            end
          end
          SDMR_PRE: begin
            if (a_s[AP_BIT]) begin
              open_d = '0;
            end else begin
              open_d[ba_s] = 1'b0;
            end
          end
          SDMR_MRS: begin
            // Writes take effect only with every bank idle
            if (open_q != '0) begin
              err_d = 1'b1;
            end else if (ba_s == BANK_MODE) begin
              mr_d = a_s;
              mr_v_d = 1'b1;
              if (a_s[MR_DLLRST_BIT] && !e1_q[E1_DLLDIS_BIT] && e1_v_q) begin
                locking_d = 1'b1;
                lock_d = '0;
              end
            end else if (ba_s == BANK_EXT1) begin
              e1_d = a_s;
              e1_v_d = 1'b1;
            end
          end
          default: begin
          end
        endcase
      end else if (cke_prev_q && !cke_s && cmd == SDMR_REF && open_q == '0) begin
        sref_d = 1'b1;
      end
    end
  end

  // Register the state
  always_ff @(posedge REF_CLK_IN) begin
    if (RESET_IN) begin
      mr_q <= MR_RESET;
      e1_q <= E1_RESET;
      mr_v_q <= 1'b0;
      e1_v_q <= 1'b0;
      open_q <= '0;
      sref_q <= 1'b0;
      lock_q <= '0;
      locking_q <= 1'b0;
      abank_q <= '0;
      arow_q <= '0;
      col_q <= '0;
      ap_q <= 1'b0;
      wr_q <= 1'b0;
      stb_q <= 1'b0;
      err_q <= 1'b0;
      cke_prev_q <= 1'b0;
    end else begin
      mr_q <= mr_d;
      e1_q <= e1_d;
      mr_v_q <= mr_v_d;
      e1_v_q <= e1_v_d;
      open_q <= open_d;
      sref_q <= sref_d;
      lock_q <= lock_d;
      locking_q <= locking_d;
      abank_q <= abank_d;
      arow_q <= arow_d;
      col_q <= col_d;
      ap_q <= ap_d;
      wr_q <= wr_d;
      stb_q <= stb_d;
      err_q <= err_d;
      cke_prev_q <= cke_prev_d;
    end
  end

  // Outputs from the registers
  assign MODE_REG_OUT = mr_q;
  assign EXT1_REG_OUT = e1_q;
  assign MODE_VALID_OUT = mr_v_q;
  assign EXT1_VALID_OUT = e1_v_q;
  // Delay line runs when enabled and not in self refresh
  assign DLL_ON_OUT = e1_v_q & ~e1_q[E1_DLLDIS_BIT] & ~sref_q;
  assign DLL_LOCKED_OUT = DLL_ON_OUT & ~locking_q;
  assign SELF_REFRESH_OUT = sref_q;
  assign ALL_IDLE_OUT = (open_q == '0);
  assign BURST_LEN_OUT = burst_len(mr_q[MR_BL_LSB +: 3]);
  assign ACT_BANK_OUT = abank_q;
  assign ACT_ROW_OUT = arow_q;
  assign COL_OUT = col_q;
  assign AUTO_PRE_OUT = ap_q;
  assign ACCESS_WRITE_OUT = wr_q;
  assign ACCESS_STB_OUT = stb_q;
  assign MRS_ERR_OUT = err_q;

endmodule : sdmr_core

/* sdmr_props.sv */
/* Checker for the mode register core outputs.
   Assumes it is bound into sdmr_core and sees only its ports. */
`timescale 1ns/1ns
module sdmr_props (
  // Clock and reset
  input wire logic REF_CLK_IN,
  input wire logic RESET_IN,
  // Register and state outputs
  input wire logic [sdmr_pkg::ADDR_W-1:0] MODE_REG_OUT,
  input wire logic [sdmr_pkg::ADDR_W-1:0] EXT1_REG_OUT,
  input wire logic [sdmr_pkg::ADDR_W-1:0] ACT_ROW_OUT,
  input wire logic MODE_VALID_OUT,
  input wire logic EXT1_VALID_OUT,
  input wire logic DLL_ON_OUT,
  input wire logic DLL_LOCKED_OUT,
  input wire logic SELF_REFRESH_OUT,
  input wire logic ALL_IDLE_OUT,
  input wire logic ACCESS_STB_OUT,
  input wire logic MRS_ERR_OUT,
  input wire logic [3:0] BURST_LEN_OUT
);
  import sdmr_pkg::*;
  // One clock domain for every check
  default clocking cb @(posedge REF_CLK_IN); endclocking
  default disable iff (RESET_IN);
  chk_burst_len: assert property (
    BURST_LEN_OUT == ((MODE_REG_OUT[2:0] == BL_CODE_8) ? 4'h8 : 4'h4))
    else $error("burst length does not follow mode field");
  chk_dll_on: assert property (
    DLL_ON_OUT == (EXT1_VALID_OUT && !EXT1_REG_OUT[E1_DLLDIS_BIT] && !SELF_REFRESH_OUT))
    else $error("delay line state wrong");
  chk_reset_unlocks: assert property (
    $changed(MODE_REG_OUT) && MODE_REG_OUT[MR_DLLRST_BIT] && DLL_ON_OUT |-> !DLL_LOCKED_OUT)
    else $error("delay line reset did not restart the lock wait");
  chk_lock_on: assert property (DLL_LOCKED_OUT |-> DLL_ON_OUT)
    else $error("locked while delay line off");
  chk_stb_pulse: assert property (ACCESS_STB_OUT |=> !ACCESS_STB_OUT)
    else $error("access strobe longer than one cycle");
  chk_err_hold: assert property (
    MRS_ERR_OUT |-> !ALL_IDLE_OUT && $stable(MODE_REG_OUT) && $stable(EXT1_REG_OUT))
    else $error("refused register set changed a register");
  chk_mode_idle: assert property ($changed(MODE_REG_OUT) |-> $past(ALL_IDLE_OUT))
    else $error("mode written with a bank open");
  chk_row_open: assert property ($changed(ACT_ROW_OUT) |-> !ALL_IDLE_OUT)
    else $error("row taken without opening a bank");
  chk_reset_clear: assert property (
    $fell(RESET_IN) |-> !MODE_VALID_OUT && !EXT1_VALID_OUT && ALL_IDLE_OUT)
    else $error("registers flagged valid after reset");
  chk_sref_idle: assert property (SELF_REFRESH_OUT |-> ALL_IDLE_OUT && !DLL_ON_OUT)
    else $error("self refresh with bank open or delay line on");
endmodule : sdmr_props

// Attach to every core instance
bind sdmr_core sdmr_props u_props (.REF_CLK_IN(REF_CLK_IN), .RESET_IN(RESET_IN),
  .MODE_REG_OUT(MODE_REG_OUT), .EXT1_REG_OUT(EXT1_REG_OUT), .ACT_ROW_OUT(ACT_ROW_OUT),
  .MODE_VALID_OUT(MODE_VALID_OUT), .EXT1_VALID_OUT(EXT1_VALID_OUT), .DLL_ON_OUT(DLL_ON_OUT),
  .DLL_LOCKED_OUT(DLL_LOCKED_OUT), .SELF_REFRESH_OUT(SELF_REFRESH_OUT),
  .ALL_IDLE_OUT(ALL_IDLE_OUT), .ACCESS_STB_OUT(ACCESS_STB_OUT), .MRS_ERR_OUT(MRS_ERR_OUT),
  .BURST_LEN_OUT(BURST_LEN_OUT));

/* sdmr_ctrl_model.sv */
/* Memory controller model: drives enable, command, bank and address pins.
   Assumes the bench supplies the link clock and the local clock. */
`timescale 1ns/1ns
module sdmr_ctrl_model (
  // Clocks
  input wire logic ck_in,
  input wire logic clk_in,
  // Pins towards the device
  output logic cke_out,
  output logic [3:0] cmd_out,
  output logic [1:0] ba_out,
  output logic [12:0] a_out
);
  // Power-up: enable low, command pins idle
  initial begin
    cke_out = 1'b0;
    cmd_out = 4'hF;
    ba_out = 2'h0;
    a_out = 13'h0000;
  end
  // One command on a link clock fall, held over the rise, then a no-op
  task automatic issue(input logic [3:0] c, input logic e, input logic [1:0] b,
                       input logic [12:0] a);
    @(negedge ck_in);
    cke_out = e;
    cmd_out = c;
    ba_out = b;
    a_out = a;
    @(posedge ck_in);
    @(negedge ck_in);
    cmd_out = 4'h7;
    ba_out = ~ba_out; // Unused lines no longer hold the old value
    a_out = ~a_out;
    repeat (2) @(negedge clk_in);
  endtask : issue
endmodule : sdmr_ctrl_model

/* testbench.sv */
/* Self-checking bench for the mode register core.
   Assumes the controller model and the bound checker are compiled first. */
`timescale 1ns/1ns
module testbench;
  import sdmr_pkg::*;
  // Command codes: chip select, row, column, write enable
  localparam logic [3:0] C_NOP = 4'h7, C_ACT = 4'h3, C_RD = 4'h5, C_WR = 4'h4;
  localparam logic [3:0] C_PRE = 4'h2, C_REF = 4'h1, C_SET = 4'h0;
  logic clk, rst, ck, cke, mv, ev, dll_on, dll_lk, sref, idle, ap, aw, stb, err;
  logic [3:0] cmd;
  logic [3:0] bl;
  logic [1:0] ba, actb;
  logic [12:0] a, mode, ext1, row, col;
  int bad_count, checked, stb_count, err_count;
  // Device under test
  sdmr_core uut (.REF_CLK_IN(clk), .RESET_IN(rst), .CK_IN(ck), .CKE_IN(cke),
    .CS_N_IN(cmd[3]), .RAS_N_IN(cmd[2]), .CAS_N_IN(cmd[1]), .WE_N_IN(cmd[0]),
    .BA_IN(ba), .A_IN(a), .MODE_REG_OUT(mode), .EXT1_REG_OUT(ext1),
    .MODE_VALID_OUT(mv), .EXT1_VALID_OUT(ev), .DLL_ON_OUT(dll_on),
    .DLL_LOCKED_OUT(dll_lk), .SELF_REFRESH_OUT(sref), .ALL_IDLE_OUT(idle),
    .BURST_LEN_OUT(bl), .ACT_BANK_OUT(actb), .ACT_ROW_OUT(row), .COL_OUT(col),
    .AUTO_PRE_OUT(ap), .ACCESS_WRITE_OUT(aw), .ACCESS_STB_OUT(stb), .MRS_ERR_OUT(err));
  // Controller on the far side
  sdmr_ctrl_model ctrl (.ck_in(ck), .clk_in(clk), .cke_out(cke), .cmd_out(cmd),
    .ba_out(ba), .a_out(a));
  // Local clock, 40 ns
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // Link clock, 320 ns, off phase
  initial begin
    ck = 1'b0;
    #7;
    forever #160 ck = ~ck;
  end
  // Count one-cycle pulses, looked at mid-cycle where they are settled
  always @(negedge clk) begin
    if (stb === 1'b1) stb_count++;
    if (err === 1'b1) err_count++;
  end
  // Compare and report
  task automatic chk(input logic [12:0] seen, input logic [12:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : chk
  // Verdict
  task automatic conclude;
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : conclude
  // Values after reset
  task automatic t_reset;
    repeat (4) @(negedge clk);
    chk(13'(mv), 13'h0000);
    chk(13'(ev), 13'h0000);
    chk(13'(bl), 13'h0004);
    chk(13'(idle), 13'h0001);
    $display("test reset done");
  endtask : t_reset
  // Full power-up sequence, calibration default then exit
  task automatic t_init;
    ctrl.issue(C_SET, 1'b0, BANK_MODE, 13'h0533); // Ignored while enable low
    chk(13'(mv), 13'h0000);
    repeat (3) ctrl.issue(C_NOP, 1'b1, 2'h0, 13'h0000);
    ctrl.issue(C_PRE, 1'b1, 2'h0, 13'h0400);
    ctrl.issue(C_SET, 1'b1, BANK_EXT2, 13'h0004);
    ctrl.issue(C_SET, 1'b1, BANK_EXT3, 13'h0004);
    chk(13'(ev), 13'h0000);
    chk(13'(mv), 13'h0000);
    ctrl.issue(C_SET, 1'b1, BANK_EXT1, 13'h0004);
    chk(ext1, 13'h0004);
    chk(13'(ev), 13'h0001);
    chk(13'(dll_on), 13'h0001);
    ctrl.issue(C_SET, 1'b1, BANK_MODE, 13'h0533);
    chk(mode, 13'h0533);
    chk(13'(mv), 13'h0001);
    chk(13'(bl), 13'h0008);
    ctrl.issue(C_PRE, 1'b1, 2'h0, 13'h0400);
    repeat (2) ctrl.issue(C_REF, 1'b1, 2'h0, 13'h0000);
    ctrl.issue(C_SET, 1'b1, BANK_MODE, 13'h0432);
    chk(mode, 13'h0432);
    chk(13'(bl), 13'h0004);
    repeat (90) ctrl.issue(C_NOP, 1'b1, 2'h0, 13'h0000); // About 189 rises
    chk(13'(dll_lk), 13'h0000);
    repeat (10) ctrl.issue(C_NOP, 1'b1, 2'h0, 13'h0000); // About 209 rises
    chk(13'(dll_lk), 13'h0001);
    ctrl.issue(C_SET, 1'b1, BANK_EXT1, 13'h0384);
    chk(ext1, 13'h0384);
    ctrl.issue(C_SET, 1'b1, BANK_EXT1, 13'h0004);
    chk(ext1, 13'h0004);
    $display("test init done");
  endtask : t_init
  // Open a bank, refused rewrite, read and write decode
  task automatic t_access;
    ctrl.issue(C_ACT, 1'b1, 2'h2, 13'h1ABC);
    chk(13'(actb), 13'h0002);
    chk(row, 13'h1ABC);
    chk(13'(idle), 13'h0000);
    ctrl.issue(C_SET, 1'b1, BANK_MODE, 13'h0533);
    chk(mode, 13'h0432);
    chk(13'(err_count), 13'h0001);
    ctrl.issue(C_RD, 1'b1, 2'h2, 13'h0404);
    chk(col, 13'h0404);
    chk(13'(ap), 13'h0001);
    chk(13'(aw), 13'h0000);
    chk(13'(idle), 13'h0001);
    ctrl.issue(C_ACT, 1'b1, 2'h2, 13'h0123);
    chk(row, 13'h0123);
    ctrl.issue(C_WR, 1'b1, 2'h2, 13'h0008);
    chk(13'(aw), 13'h0001);
    chk(13'(ap), 13'h0000);
    chk(13'(stb_count), 13'h0002);
    chk(13'(idle), 13'h0000);
    ctrl.issue(C_PRE, 1'b1, 2'h0, 13'h0400);
    chk(13'(idle), 13'h0001);
    $display("test access done");
  endtask : t_access
  // Self refresh entry and exit, then delay line disable
  task automatic t_sref;
    ctrl.issue(C_REF, 1'b0, 2'h0, 13'h0000);
    chk(13'(sref), 13'h0001);
    chk(13'(dll_on), 13'h0000);
    ctrl.issue(C_NOP, 1'b1, 2'h0, 13'h0000);
    chk(13'(sref), 13'h0000);
    chk(13'(dll_on), 13'h0001);
    ctrl.issue(C_SET, 1'b1, BANK_EXT1, 13'h0005);
    chk(13'(dll_on), 13'h0000);
    $display("test self refresh done");
  endtask : t_sref
  // Main sequence
  initial begin
    rst = 1'b1;
    bad_count = 0;
    checked = 0;
    stb_count = 0;
    err_count = 0;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    t_reset;
    t_init;
    t_access;
    t_sref;
    conclude;
  end
  // Watchdog, about four times the expected run
  initial begin
    #300000;
    bad_count++;
    conclude;
  end
endmodule : testbench
